// ---- mfx_pkg.sv ----
// Shared constants, opcode map and carrier types of the multifunction instruction core.
//
// Operation
// - The exchange_step_skip instruction swaps A with the word at B, steps B, compares B with K and skips the next instruction once B has passed K.
// - The one-byte short_jump moves the program counter by a signed displacement of at most 32 locations either way.
// - The one-byte table_call pushes the return address and then loads one of 16 table entries into the program counter.
// - The two-byte relative_call reaches any entry within about 1k locations either side of the program counter.
// - The bit_set_op, bit_clear_op and bit_test_op instructions act on any bit of a byte addressed directly or through B.
// - Registers stay inside the core, outside the memory map; memory-operand and bit instructions reach only what answers on the memory port.
// - Decimal add and subtract give correct packed decimal results on four-digit words and two-digit bytes.
// - The arithmetic unit multiplies 16 by 16 bits, divides 16 by 16 bits and divides a 32-bit dividend by 16 bits.
// - Multiply and divide take their second operand as immediate data or as a value read from memory.
`default_nettype none

package mfx_pkg;

   // Reset values and table placement.
   localparam logic [15:0] MFX_PC_RESET   = 16'h0000;
   localparam logic [15:0] MFX_SP_RESET   = 16'h0100;
   localparam logic [15:0] MFX_TABLE_BASE = 16'h0040;

   // Iterative divider length, one quotient bit per clock.
   localparam int unsigned MFX_DIV_STEPS = 32;

   // Single opcodes.
   localparam logic [7:0] MFX_OP_NOP    = 8'h00;
   localparam logic [7:0] MFX_OP_LDA    = 8'h01;
   localparam logic [7:0] MFX_OP_LDB    = 8'h02;
   localparam logic [7:0] MFX_OP_LDK    = 8'h03;
   localparam logic [7:0] MFX_OP_XS_INC = 8'h10;
   localparam logic [7:0] MFX_OP_XS_DEC = 8'h11;

   // Opcode groups: value of the fixed upper bits.
   localparam logic [4:0] MFX_GRP_RCALL = 5'h04;   // 0010_0ddd, then one displacement byte.
   localparam logic [3:0] MFX_GRP_TCALL = 4'h3;    // 0011_iiii.
   localparam logic [1:0] MFX_GRP_JUMP  = 2'h1;    // 01dd_dddd.
   localparam logic [1:0] MFX_GRP_BIT   = 2'h2;    // 10oo_mbbb.
   localparam logic [1:0] MFX_GRP_ARITH = 2'h3;    // 11bm_0ccc.

   // Field positions.
   localparam int unsigned MFX_F_BITMODE = 3;      // Bit ops: 1 = direct 16-bit address.
   localparam int unsigned MFX_F_ARMEM   = 4;      // Arithmetic: 1 = operand from memory.
   localparam int unsigned MFX_F_ARBYTE  = 5;      // Arithmetic: 1 = decimal on bytes.

   // Bit operation codes, opcode bits 5:4.
   localparam logic [1:0] MFX_BIT_SET   = 2'h0;
   localparam logic [1:0] MFX_BIT_CLEAR = 2'h1;
   localparam logic [1:0] MFX_BIT_TEST  = 2'h2;

   // Arithmetic operation codes, opcode bits 2:0.
   localparam logic [2:0] MFX_AR_DADC = 3'h0;
   localparam logic [2:0] MFX_AR_DSBC = 3'h1;
   localparam logic [2:0] MFX_AR_MULT = 3'h2;
   localparam logic [2:0] MFX_AR_DIV  = 3'h3;
   localparam logic [2:0] MFX_AR_DIVD = 3'h4;

   // Pointer step of the exchange instruction, in bytes.
   localparam logic [15:0] MFX_XS_STEP = 16'h0002;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mfx_mem_req_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] x;
      logic [15:0] k;
      logic [15:0] sp;
      logic        carry;
      logic        skip;
   } mfx_regs_t;

endpackage : mfx_pkg

`default_nettype wire

// ---- mfx_bcd_digit.sv ----
// One packed decimal digit adder with carry, chained for byte and word decimal arithmetic.
`default_nettype none

module mfx_bcd_digit (
   // Operand digits and carry in.
   input  wire logic [3:0] a,
   input  wire logic [3:0] b,
   input  wire logic       cin,
   // Result digit and carry out.
   output logic      [3:0] sum,
   output logic            cout
);

   logic [4:0] raw;

   assign raw  = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   assign cout = raw > 5'h09;
   // Adding six folds the binary overflow of a digit back into 0..9.
   assign sum  = cout ? 4'(raw + 5'h06) : raw[3:0];

endmodule : mfx_bcd_digit

`default_nettype wire

// ---- mfx_core.sv ----
// Instruction sequencer for exchange-and-skip, short and table calls, bit ops and decimal/mul/div.
`default_nettype none

module mfx_core #(
   parameter logic [15:0] TABLE_BASE = mfx_pkg::MFX_TABLE_BASE,
   parameter logic [15:0] PC_RESET   = mfx_pkg::MFX_PC_RESET,
   parameter logic [15:0] SP_RESET   = mfx_pkg::MFX_SP_RESET
) (
   // Clock, reset and freeze.
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   // Program and data memory, one request at a time.
   output var  mfx_pkg::mfx_mem_req_t mem_req,
   input  wire logic                  mem_ack,
   input  wire logic [15:0]           mem_rdata,
   // Architectural state.
   output var  mfx_pkg::mfx_regs_t    regs
);

   import mfx_pkg::*;

   typedef enum logic [3:0] {
      S_FETCH, S_OPND, S_EXEC, S_RD, S_ALU, S_WR, S_PUSH, S_TBL, S_DIV
   } mfx_state_t;

   mfx_state_t   state_q;
   mfx_mem_req_t mreq_q;
   logic [15:0]  pc_q, a_q, b_q, x_q, k_q, sp_q;
   logic         c_q, skip_q, tcall_q;
   logic [7:0]   op_q;
   logic [1:0]   nrem_q;
   logic [15:0]  imm_q, ea_q, opnd_q, tgt_q, ret_q, wdat_q;
   logic [31:0]  quo_q;
   logic [16:0]  rem_q;
   logic [5:0]   cnt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode.

   // Operand bytes that follow an opcode; a skip must step over these too.
   function automatic logic [1:0] opnd_len(input logic [7:0] o);
      logic [1:0] n;
      n = 2'd0;
      if (o == MFX_OP_LDA || o == MFX_OP_LDB || o == MFX_OP_LDK) n = 2'd2;
      else if (o[7:3] == MFX_GRP_RCALL) n = 2'd1;
      else if (o[7:6] == MFX_GRP_BIT && o[MFX_F_BITMODE]) n = 2'd2;
      else if (o[7:6] == MFX_GRP_ARITH) begin
         if (o[MFX_F_ARMEM]) n = 2'd2;
         else if (o[MFX_F_ARBYTE] && o[2:1] == 2'd0) n = 2'd1;
         else n = 2'd2;
      end
      return n;
   endfunction : opnd_len

   function automatic mfx_mem_req_t mk_req(input logic we, input logic word,
                                           input logic [15:0] addr, input logic [15:0] wd);
      mfx_mem_req_t r;
      r.req   = 1'b1;
      r.we    = we;
      r.word  = word;
      r.addr  = addr;
      r.wdata = wd;
      return r;
   endfunction : mk_req

   logic is_jp, is_rcall, is_tcall, is_xs, is_bit, is_ar, dec_byte, rd_word, xs_passed;
   logic [2:0]  ar_code;
   logic [15:0] b_step;
   logic [7:0]  bit_mask;

   assign is_jp     = op_q[7:6] == MFX_GRP_JUMP;
   assign is_rcall  = op_q[7:3] == MFX_GRP_RCALL;
   assign is_tcall  = op_q[7:4] == MFX_GRP_TCALL;
   assign is_xs     = op_q == MFX_OP_XS_INC || op_q == MFX_OP_XS_DEC;
   assign is_bit    = op_q[7:6] == MFX_GRP_BIT && op_q[5:4] != 2'h3;
   assign ar_code   = op_q[2:0];
   assign is_ar     = op_q[7:6] == MFX_GRP_ARITH && !op_q[3] && ar_code <= MFX_AR_DIVD;
   assign dec_byte  = op_q[MFX_F_ARBYTE] && (ar_code == MFX_AR_DADC || ar_code == MFX_AR_DSBC);
   assign rd_word   = is_xs || (is_ar && !dec_byte);
   assign bit_mask  = 8'h01 << op_q[2:0];
   assign b_step    = op_q[0] ? b_q - MFX_XS_STEP : b_q + MFX_XS_STEP;
   assign xs_passed = op_q[0] ? b_step < k_q : b_step > k_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Packed decimal adder; subtraction adds the nines' complement plus carry.

   logic [15:0] bcd_b, bcd_sum;
   logic [4:0]  bcd_c;

   assign bcd_c[0] = c_q;

   for (genvar i = 0; i < 4; i++) begin : g_digit
      assign bcd_b[4*i +: 4] = (ar_code == MFX_AR_DSBC) ? 4'h9 - opnd_q[4*i +: 4]
                                                         : opnd_q[4*i +: 4];
      mfx_bcd_digit u_digit (
         .a   (a_q[4*i +: 4]),
         .b   (bcd_b[4*i +: 4]),
         .cin (bcd_c[i]),
         .sum (bcd_sum[4*i +: 4]),
         .cout(bcd_c[i+1])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Restoring divider step; a zero divisor yields an all-ones quotient.

   logic [16:0] div_sh;
   logic        div_ge;
   logic [31:0] div_quo_n;
   logic [16:0] div_rem_n;

   assign div_sh    = {rem_q[15:0], quo_q[31]};
   assign div_ge    = div_sh >= {1'b0, opnd_q};
   assign div_quo_n = {quo_q[30:0], div_ge};
   assign div_rem_n = div_ge ? div_sh - {1'b0, opnd_q} : div_sh;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= S_FETCH;
         mreq_q  <= '0;
         pc_q    <= PC_RESET;
         sp_q    <= SP_RESET;
         {a_q, b_q, x_q, k_q} <= '0;
         {c_q, skip_q, tcall_q} <= '0;
         op_q    <= 8'h00;
         nrem_q  <= 2'd0;
         {imm_q, ea_q, opnd_q, tgt_q, ret_q, wdat_q} <= '0;
         quo_q   <= 32'h0000_0000;
         rem_q   <= '0;
         cnt_q   <= '0;
      end else if (ce) begin
         case (state_q)
            S_FETCH: begin
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  op_q       <= mem_rdata[7:0];
                  pc_q       <= pc_q + 16'h0001;
                  nrem_q     <= opnd_len(mem_rdata[7:0]);
                  imm_q      <= 16'h0000;
                  if (opnd_len(mem_rdata[7:0]) != 2'd0) state_q <= S_OPND;
                  else if (skip_q) skip_q <= 1'b0;
                  else state_q <= S_EXEC;
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b0, 1'b0, pc_q, 16'h0000);
               end
            end
            S_OPND: begin
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  pc_q       <= pc_q + 16'h0001;
                  nrem_q     <= nrem_q - 2'd1;
                  // Operands are little-endian: the first byte is the low byte.
                  if (nrem_q == 2'd1 && opnd_len(op_q) == 2'd2)
                     imm_q <= {mem_rdata[7:0], imm_q[7:0]};
                  else
                     imm_q <= {8'h00, mem_rdata[7:0]};
                  if (nrem_q == 2'd1) begin
                     state_q <= skip_q ? S_FETCH : S_EXEC;
                     skip_q  <= 1'b0;
                  end
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b0, 1'b0, pc_q, 16'h0000);
               end
            end
            S_EXEC: begin
               opnd_q  <= imm_q;
               state_q <= S_FETCH;
               if (op_q == MFX_OP_LDA) a_q <= imm_q;
               else if (op_q == MFX_OP_LDB) b_q <= imm_q;
               else if (op_q == MFX_OP_LDK) k_q <= imm_q;
               else if (is_jp) begin
                  pc_q <= pc_q + {{10{op_q[5]}}, op_q[5:0]};
               end else if (is_rcall) begin
                  ret_q   <= pc_q;
                  tgt_q   <= pc_q + {{5{op_q[2]}}, op_q[2:0], imm_q[7:0]};
                  tcall_q <= 1'b0;
                  state_q <= S_PUSH;
               end else if (is_tcall) begin
                  ret_q   <= pc_q;
                  tgt_q   <= TABLE_BASE + {11'h000, op_q[3:0], 1'b0};
                  tcall_q <= 1'b1;
                  state_q <= S_PUSH;
               end else if (is_xs) begin
                  ea_q    <= b_q;
                  state_q <= S_RD;
               end else if (is_bit) begin
                  ea_q    <= op_q[MFX_F_BITMODE] ? imm_q : b_q;
                  state_q <= S_RD;
               end else if (is_ar) begin
                  ea_q    <= imm_q;
                  state_q <= op_q[MFX_F_ARMEM] ? S_RD : S_ALU;
               end
            end
            S_RD: begin
               // Any address goes to the one memory port; the core's own registers are not reachable there.
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  opnd_q     <= rd_word ? mem_rdata : {8'h00, mem_rdata[7:0]};
                  state_q    <= S_ALU;
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b0, rd_word, ea_q, 16'h0000);
               end
            end
            S_ALU: begin
               state_q <= S_FETCH;
               if (is_xs) begin
                  a_q     <= opnd_q;
                  wdat_q  <= a_q;
                  b_q     <= b_step;
                  skip_q  <= xs_passed;
                  state_q <= S_WR;
               end else if (is_bit) begin
                  if (op_q[5:4] == MFX_BIT_TEST) begin
                     skip_q <= ~opnd_q[op_q[2:0]];
                  end else begin
                     wdat_q  <= (op_q[5:4] == MFX_BIT_CLEAR)
                                ? {8'h00, opnd_q[7:0] & ~bit_mask}
                                : {8'h00, opnd_q[7:0] | bit_mask};
                     state_q <= S_WR;
                  end
               end else begin
                  case (ar_code)
                     MFX_AR_DADC, MFX_AR_DSBC: begin
                        a_q <= dec_byte ? {8'h00, bcd_sum[7:0]} : bcd_sum;
                        c_q <= dec_byte ? bcd_c[2] : bcd_c[4];
                     end
                     MFX_AR_MULT: {x_q, a_q} <= 32'(a_q) * 32'(opnd_q);
                     MFX_AR_DIV, MFX_AR_DIVD: begin
                        quo_q   <= (ar_code == MFX_AR_DIVD) ? {x_q, a_q}
                                                            : {16'h0000, a_q};
                        rem_q   <= '0;
                        cnt_q   <= '0;
                        state_q <= S_DIV;
                     end
                     default: state_q <= S_FETCH;
                  endcase
               end
            end
            S_DIV: begin
               quo_q <= div_quo_n;
               rem_q <= div_rem_n;
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'(MFX_DIV_STEPS - 1)) begin
                  a_q     <= div_quo_n[15:0];
                  x_q     <= div_rem_n[15:0];
                  state_q <= S_FETCH;
               end
            end
            S_WR: begin
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  state_q    <= S_FETCH;
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b1, is_xs, ea_q, wdat_q);
               end
            end
            S_PUSH: begin
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  sp_q       <= sp_q + 16'h0002;
                  if (tcall_q) begin
                     state_q <= S_TBL;
                  end else begin
                     pc_q    <= tgt_q;
                     state_q <= S_FETCH;
                  end
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b1, 1'b1, sp_q, ret_q);
               end
            end
            S_TBL: begin
               if (mem_ack) begin
                  mreq_q.req <= 1'b0;
                  pc_q       <= mem_rdata;
                  state_q    <= S_FETCH;
               end else if (!mreq_q.req) begin
                  mreq_q <= mk_req(1'b0, 1'b1, tgt_q, 16'h0000);
               end
            end
            default: state_q <= S_FETCH;
         endcase
      end
   end

   assign mem_req = mreq_q;
   assign regs    = '{pc: pc_q, a: a_q, b: b_q, x: x_q, k: k_q, sp: sp_q,
                      carry: c_q, skip: skip_q};

endmodule : mfx_core

`default_nettype wire

// ---- mfx_mem_model.sv ----
// Behavioural program and data memory that answers the core after a random wait.
`default_nettype none

module mfx_mem_model (
   // Clock, reset and pace.
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   input  wire logic                  slow,
   // Memory port.
   input  wire mfx_pkg::mfx_mem_req_t mem_req,
   output logic                       mem_ack,
   output logic [15:0]                mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import mfx_pkg::*;

   logic [7:0] mem [65536];

   // Between answers the read data toggles, so a stale word is never taken for an answer.
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 16'h5A5A;
      end else if (mem_req.req && !mem_ack && (!slow || $urandom_range(3) == 0)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= {mem[mem_req.addr + 16'h0001], mem[mem_req.addr]};
         if (mem_req.we) begin
            mem[mem_req.addr] <= mem_req.wdata[7:0];
            if (mem_req.word) begin
               mem[mem_req.addr + 16'h0001] <= mem_req.wdata[15:8];
            end
         end
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end

endmodule : mfx_mem_model

`default_nettype wire

// ---- mfx_core_checker.sv ----
// Port-level assertions for the multifunction instruction core.
`default_nettype none

module mfx_core_checker #(
   parameter logic [15:0] TABLE_BASE = mfx_pkg::MFX_TABLE_BASE,
   parameter logic [15:0] PC_RESET   = mfx_pkg::MFX_PC_RESET
) (
   // Clock and reset.
   input wire logic                  clock,
   input wire logic                  arst_n,
   input wire logic                  ce,
   // Memory port and state.
   input wire mfx_pkg::mfx_mem_req_t mem_req,
   input wire logic                  mem_ack,
   input wire logic [15:0]           mem_rdata,
   input wire mfx_pkg::mfx_regs_t    regs
);
   timeunit 1ns;
   timeprecision 100ps;
   import mfx_pkg::*;

   logic        take;
   logic [15:0] hold_q;

   assign take = mem_req.req && mem_ack && ce;

   // Accesses are at least three edges apart, so one register serves writes and reads.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hold_q <= 16'h0000;
      end else if (take) begin
         hold_q <= mem_req.we ? mem_req.addr : mem_rdata;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////
   property p_first_fetch;
      $rose(arst_n) && ce |=> mem_req.req && !mem_req.we && mem_req.addr == PC_RESET;
   endproperty
   a_first_fetch: assert property (p_first_fetch) else $error("no fetch after reset");
   property p_req_hold;
      mem_req.req && !(mem_ack && ce) |=> mem_req.req && $stable(mem_req);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved early");
   property p_freeze;
      !ce |=> $stable(regs) && $stable(mem_req);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   property p_skip_state;
      regs.skip && ce |=> $stable({regs.a, regs.b, regs.x, regs.k, regs.sp, regs.carry});
   endproperty
   a_skip_state: assert property (p_skip_state) else $error("skipped code changed state");
   property p_push_sp;
      take && mem_req.we && mem_req.word && mem_req.addr == regs.sp
         |=> ##[0:2] regs.sp == hold_q + 16'h0002;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("stack pointer not stepped");
   property p_table_pc;
      take && !mem_req.we && mem_req.word && mem_req.addr[15:5] == TABLE_BASE[15:5]
         |=> ##[0:2] regs.pc == hold_q;
   endproperty
   a_table_pc: assert property (p_table_pc) else $error("table entry not loaded");
   // The pointer has already stepped when the old A is written back to the word it named.
   property p_xs_step;
      take && mem_req.we && mem_req.word && mem_req.addr != regs.sp
         |-> (regs.b == mem_req.addr + 16'h0002 || regs.b == mem_req.addr - 16'h0002);
   endproperty
   a_xs_step: assert property (p_xs_step) else $error("pointer not stepped");
   property p_byte_wr;
      mem_req.req && mem_req.we && !mem_req.word |-> mem_req.wdata[15:8] == 8'h00;
   endproperty
   a_byte_wr: assert property (p_byte_wr) else $error("byte write high byte set");

endmodule : mfx_core_checker

bind mfx_core mfx_core_checker #(.TABLE_BASE(TABLE_BASE), .PC_RESET(PC_RESET)) chk_u (
   .clock(clock), .arst_n(arst_n), .ce(ce), .mem_req(mem_req), .mem_ack(mem_ack),
   .mem_rdata(mem_rdata), .regs(regs));

`default_nettype wire

// ---- tb_mfx_core.sv ----
// Self-checking bench: short programs on the core against a behavioural memory.
`default_nettype none

module tb_mfx_core;
   timeunit 1ns;
   timeprecision 100ps;
   import mfx_pkg::*;

   logic         clock = 1'b0;
   logic         arst_n = 1'b0;
   logic         ce = 1'b1;
   logic         slow = 1'b0;
   mfx_mem_req_t mem_req;
   logic         mem_ack;
   logic [15:0]  mem_rdata;
   mfx_regs_t    regs;
   logic [31:0]  exp_q[$];
   logic [31:0]  w;
   int           miscompares = 0;
   int           compares = 0;

   mfx_core dut_u (.clock(clock), .arst_n(arst_n), .ce(ce), .mem_req(mem_req),
                   .mem_ack(mem_ack), .mem_rdata(mem_rdata), .regs(regs));
   mfx_mem_model mem_u (.clock(clock), .arst_n(arst_n), .slow(slow), .mem_req(mem_req),
                        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   always #4 clock = ~clock;

   ////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      compares++;
      if (got !== want) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check

   task automatic complete_run;
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic put(input logic [15:0] ad, input logic [15:0] d);
      mem_u.mem[ad] = d[7:0];
      mem_u.mem[ad + 16'h0001] = d[15:8];
   endtask : put

   // Memory is cleared while reset is held, so stray jumps run into no-operations.
   task automatic prep(input logic [7:0] p[$]);
      @(posedge clock);
      arst_n <= 1'b0;
      slow   <= 1'($urandom_range(1));
      exp_q.delete();
      for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'h00;
      foreach (p[i]) mem_u.mem[i] = p[i];
      repeat (8) @(posedge clock);
   endtask : prep

   // Every program ends in a jump to itself; two fetches there mark the end.
   task automatic go(input logic [15:0] end_pc, input bit rand_ce);
      int seen;
      int n;
      seen = 0;
      arst_n <= 1'b1;
      for (n = 0; n < 4000 && seen < 2; n++) begin
         @(posedge clock);
         if (mem_req.req && mem_ack && ce && !mem_req.we && mem_req.addr === end_pc) seen++;
         ce <= rand_ce ? 1'($urandom_range(3) != 0) : 1'b1;
      end
      ce <= 1'b1;
      check(16'(seen), 16'h0002);
      check(16'(exp_q.size()), 16'h0000);
   endtask : go

   function automatic logic [16:0] bcd(input logic [15:0] x, input logic [15:0] y,
                                       input logic c, input bit sub, input int nd);
      logic [16:0] r;
      int          t;
      r = '0;
      for (int i = 0; i < nd; i++) begin
         t = sub ? int'(x[4*i+:4]) - int'(y[4*i+:4]) - int'(!c)
                 : int'(x[4*i+:4]) + int'(y[4*i+:4]) + int'(c);
         c = sub ? t >= 0 : t > 9;
         t = sub ? (c ? t : t + 10) : (c ? t - 10 : t);
         r[4*i+:4] = 4'(t);
      end
      r[16] = c;
      return r;
   endfunction : bcd

   function automatic logic [15:0] rbcd();
      return {4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(9)),
              4'($urandom_range(9))};
   endfunction : rbcd

   always @(posedge clock) begin
      if (arst_n && ce && mem_req.req && mem_req.we && mem_ack) begin
         w = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFF_FFFF;
         check(mem_req.addr, w[31:16]);
         check(mem_req.wdata, w[15:0]);
      end
   end

   ////////////////////////////////////////
   initial begin
      logic [15:0] a, b, c, bs, st, m0, m1, m2;
      logic [16:0] r;
      logic [31:0] pr;
      logic [7:0]  v, m, d8;
      int          n;
      void'($urandom(5027));
      for (int d = 0; d < 2; d++) begin
         a  = 16'($urandom);
         bs = d ? 16'h0204 : 16'h0200;
         st = d ? 16'hFFFE : 16'h0002;
         prep('{8'h01, a[7:0], a[15:8], 8'h02, bs[7:0], bs[15:8], 8'h03, 8'h02, 8'h02,
                8'h10 | 8'(d), 8'h10 | 8'(d), 8'h01, 8'h55, 8'h55, 8'h7F});
         put(bs, 16'hAAAA);
         put(bs + st, 16'hBBBB);
         exp_q.push_back({bs, a});
         exp_q.push_back({bs + st, 16'hAAAA});
         go(16'h000E, 1'b0);
         check(regs.a, 16'hBBBB);
         check(regs.k, 16'h0202);
         check(regs.b, bs + st + st);
      end
      prep('{8'h5F});
      mem_u.mem[16'h0020] = 8'h60;
      mem_u.mem[16'h0001] = 8'h7F;
      go(16'h0001, 1'b1);
      for (int i = 0; i < 16; i++) begin
         prep('{8'h30 | 8'(i)});
         put(MFX_TABLE_BASE + 16'(2 * i), 16'h0080 + 16'(i));
         mem_u.mem[16'h0080 + i] = 8'h7F;
         exp_q.push_back({MFX_SP_RESET, 16'h0001});
         go(16'h0080 + 16'(i), 1'b0);
         check(regs.sp, MFX_SP_RESET + 16'h0002);
      end
      for (int j = 0; j < 2; j++) begin
         b = j ? 16'hFC02 : 16'h0401;
         prep('{8'h23 + 8'(j), j ? 8'h00 : 8'hFF});
         mem_u.mem[b] = 8'h7F;
         exp_q.push_back({MFX_SP_RESET, 16'h0002});
         go(b, 1'b0);
      end
      n = $urandom_range(7);
      v = 8'($urandom);
      m = 8'h01 << n;
      prep('{8'h88 | 8'(n), 8'h00, 8'h03, 8'h02, 8'h00, 8'h03, 8'h90 | 8'(n),
             8'hA8 | 8'(n), 8'h00, 8'h03, 8'h01, 8'h77, 8'h77, 8'h7F});
      mem_u.mem[16'h0300] = v;
      exp_q.push_back({16'h0300, 8'h00, v | m});
      exp_q.push_back({16'h0300, 8'h00, v & ~m});
      go(16'h000D, 1'b0);
      check(regs.a, 16'h0000);
      a  = rbcd();
      b  = rbcd();
      c  = rbcd();
      d8 = 8'(rbcd());
      prep('{8'h01, a[7:0], a[15:8], 8'hC0, b[7:0], b[15:8], 8'hD0, 8'h00, 8'h05,
             8'hE1, d8, 8'h7F});
      put(16'h0500, c);
      r = bcd(a, b, 1'b0, 0, 4);
      r = bcd(r[15:0], c, r[16], 0, 4);
      r = bcd({8'h00, r[7:0]}, {8'h00, d8}, r[16], 1, 2);
      go(16'h000B, 1'b0);
      check(regs.a, {8'h00, r[7:0]});
      check({15'h0000, regs.carry}, {15'h0000, r[16]});
      a  = 16'($urandom);
      m0 = 16'($urandom_range(65535, 1));
      m1 = 16'($urandom);
      m2 = 16'($urandom_range(65535, 1));
      prep('{8'h01, a[7:0], a[15:8], 8'hD3, 8'h00, 8'h05, 8'hC2, m1[7:0], m1[15:8],
             8'hC4, m2[7:0], m2[15:8], 8'h7F});
      put(16'h0500, m0);
      pr = 32'(a / m0) * 32'(m1);
      go(16'h000C, 1'b1);
      check(regs.a, 16'(pr / 32'(m2)));
      check(regs.x, 16'(pr % 32'(m2)));
      complete_run();
   end

   // Sized from 24 programs; a hung one stops its own wait after 4,000 cycles.
   initial begin
      repeat (95000) @(posedge clock);
      miscompares++;
      complete_run();
   end

endmodule : tb_mfx_core

`default_nettype wire
